// >>> inc/aso_map.svh
// register offsets, field positions, codes and timing counts of the sample output port
`ifndef ASO_MAP_SVH
`define ASO_MAP_SVH

`define ASO_DW            11
`define ASO_AW            8
// register offsets
`define ASO_CTRL_OFS      8'h00
`define ASO_STAT_OFS      8'h04
// control fields and their reset values
`define ASO_CTRL_PD_BIT   0
`define ASO_CTRL_DLL_BIT  1
`define ASO_PD_RST        1'b0
`define ASO_DLLOFF_RST    1'b0
// status fields
`define ASO_STAT_DOWN_BIT 0
`define ASO_STAT_SLOW_BIT 1
`define ASO_STAT_CRST_BIT 2
`define ASO_STAT_SWPD_BIT 3
`define ASO_STAT_OE_BIT   4
`define ASO_STAT_FMT_LSB  5
// timing
`define ASO_CLK_MHZ       100
`define ASO_SLOW_NS       500
`define ASO_SLOW_CYC      ((`ASO_SLOW_NS * `ASO_CLK_MHZ) / 1000)
`define ASO_RSTPIN_NS     2000
`define ASO_RST_CYC       ((`ASO_RSTPIN_NS * `ASO_CLK_MHZ + 999) / 1000)
`define ASO_LAT_WHOLE     17
// full-scale codes
`define ASO_SOB_POS       11'h7ff
`define ASO_SOB_NEG       11'h000
`define ASO_TWO_POS       11'h3ff
`define ASO_TWO_NEG       11'h400
`define ASO_TWOS_FLIP     11'h400
// format select pin fields
`define ASO_FMT_TWOS_BIT  1
`define ASO_FMT_FALL_BIT  0

`endif

// >>> inc/aso_pkg.sv
// types shared by the sample output port
`include "aso_map.svh"
package aso_pkg;
    // one converted sample as it leaves the core
    typedef struct packed {
        logic [`ASO_DW-1:0] code;
        logic               pos;
        logic               neg;
    } aso_raw_t;

    // power state of the output port
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_DOWN_SW,
        PWR_DOWN_SLOW,
        PWR_RESET
    } aso_pwr_t;
endpackage

// >>> hw/aso_sync.sv
// two flip-flop level synchroniser
module aso_sync #(
    parameter int W = 1
) (
    input  wire logic         clk, // destination clock
    input  wire logic [W-1:0] d,   // level from another domain
    output logic      [W-1:0] q    // synchronised level
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        meta_q <= d;
        q      <= meta_q;
    end
endmodule

// >>> hw/aso_delay_mem.sv
// small delay memory with registered read data
module aso_delay_mem #(
    parameter int W     = 13,
    parameter int DEPTH = 17,
    parameter int AW    = 5
) (
    input  wire logic          clk,   // link clock
    input  wire logic          we,    // write strobe
    input  wire logic [AW-1:0] waddr, // write address
    input  wire logic [W-1:0]  wdata, // write data
    input  wire logic [AW-1:0] raddr, // read address
    output logic      [W-1:0]  rdata  // registered read data
);
    logic [W-1:0] mem [DEPTH];

    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read port, old contents on a same-address collision
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

// >>> hw/aso_top.sv
// sample output port: latency line, output coding, power control and register slave
`include "aso_map.svh"
module aso_top #(
    parameter int DEPTH = `ASO_LAT_WHOLE,
    parameter int PW    = 5
) (
    input  wire logic               CLK,            // system clock, 100 MHz
    input  wire logic               RST_B,          // synchronous reset, active low
    input  wire logic               PSEL,           // apb select
    input  wire logic               PENABLE,        // apb enable
    input  wire logic               PWRITE,         // apb direction
    input  wire logic [`ASO_AW-1:0] PADDR,          // apb byte address
    input  wire logic [31:0]        PWDATA,         // apb write data
    output logic      [31:0]        PRDATA,         // apb read data
    output logic                    PREADY,         // apb ready
    output logic                    PSLVERR,        // apb error on unmapped address
    input  wire logic               LINK_CLK,       // converter input clock
    input  wire logic [`ASO_DW-1:0] CORE_CODE,      // core result, offset binary
    input  wire logic               CORE_OVER_POS,  // core positive overdrive
    input  wire logic               CORE_OVER_NEG,  // core negative overdrive
    input  wire logic [1:0]         FMT_SEL,        // four-level format select pin
    input  wire logic               OE_PIN,         // output enable pin, active high
    input  wire logic               CFG_RESET,      // reset pin, active high
    output logic      [`ASO_DW-1:0] SAMPLE_OUT,     // parallel sample word
    output logic                    OVER_RANGE,     // over-range flag
    output logic                    DATA_READY_CLK, // data-ready output clock
    output logic                    OUT_OE,         // output enable of all outputs
    output logic                    DLL_EN,         // delay-lock loop enable
    output logic                    CORE_PWRDN      // core off, reference stays on
);
    localparam logic [7:0]    IDLEC = 8'(`ASO_SLOW_CYC);
    localparam logic [7:0]    RSTC  = 8'(`ASO_RST_CYC);
    localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1);
    localparam logic [PW-1:0] FULL  = PW'(DEPTH);

    // ---- system clock domain ----
    logic              pin_rst_s;
    logic              oe_s;
    logic [1:0]        fmt_s;
    logic              hb_s;
    logic              hb_prev_q;
    logic [7:0]        idle_q;
    logic [7:0]        rstcnt_q;
    logic              slow;
    logic              cfg_rst;
    logic              pd_q;
    logic              dll_off_q;
    aso_pkg::aso_pwr_t pwr_q;
    aso_pkg::aso_pwr_t pwr_d;
    logic              run_c_q;
    logic              lrst_c_q;
    logic              acc;
    logic              wr_ctrl;

    // ---- link clock domain ----
    logic              run_l;
    logic              lrst_l;
    logic [1:0]        fmt_l;
    logic              hb_q;
    logic              phase_q;
    logic [PW-1:0]     wr_ptr_q;
    logic [PW-1:0]     fill_q;
    aso_pkg::aso_raw_t cap_q;
    aso_pkg::aso_raw_t rd_q;
    logic              twos_l;

    // address decode shared by read, write and error paths
    function automatic logic hit(input logic [`ASO_AW-1:0] a, input logic [`ASO_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // full-scale codes of the selected coding
    function automatic logic [`ASO_DW-1:0] fs_pos(input logic twos);
        fs_pos = twos ? `ASO_TWO_POS : `ASO_SOB_POS;
    endfunction

    function automatic logic [`ASO_DW-1:0] fs_neg(input logic twos);
        fs_neg = twos ? `ASO_TWO_NEG : `ASO_SOB_NEG;
    endfunction

    // circular pointer advance
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == LAST) ? '0 : p + PW'(1);
    endfunction

    // pins and link heartbeat brought into the system clock
    aso_sync #(.W(4)) u_pin_sync (
        .clk (CLK),
        .d   ({CFG_RESET, OE_PIN, FMT_SEL}),
        .q   ({pin_rst_s, oe_s, fmt_s})
    );

    aso_sync #(.W(1)) u_hb_sync (
        .clk (CLK),
        .d   (hb_q),
        .q   (hb_s)
    );

    // reset pin must stay high for the minimum pulse width before it counts
    always_ff @(posedge CLK) begin
        if (!RST_B || !pin_rst_s) begin
            rstcnt_q <= '0;
        end else if (rstcnt_q != RSTC) begin
            rstcnt_q <= rstcnt_q + 8'h01;
        end
    end
    assign cfg_rst = (rstcnt_q == RSTC);

    // idle time since the last rising link clock edge, saturating at the threshold
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            hb_prev_q <= 1'b0;
            idle_q    <= '0;
        end else begin
            hb_prev_q <= hb_s;
            // a pin reset parks the heartbeat itself, so it must not read as a slow clock
            if ((hb_s != hb_prev_q) || cfg_rst) begin
                idle_q <= '0;
            end else if (idle_q != IDLEC) begin
                idle_q <= idle_q + 8'h01;
            end
        end
    end
    assign slow = (idle_q == IDLEC);

    // apb handshake: one wait-free access phase
    assign acc     = PSEL && PENABLE && PREADY;
    assign wr_ctrl = acc && PWRITE && hit(PADDR, `ASO_CTRL_OFS);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit(PADDR, `ASO_CTRL_OFS)
                       && !hit(PADDR, `ASO_STAT_OFS);
            PRDATA  <= '0;
            if (PSEL && !PENABLE && !PWRITE) begin
                if (hit(PADDR, `ASO_CTRL_OFS)) begin
                    PRDATA[`ASO_CTRL_PD_BIT]  <= pd_q;
                    PRDATA[`ASO_CTRL_DLL_BIT] <= dll_off_q;
                end else if (hit(PADDR, `ASO_STAT_OFS)) begin
                    PRDATA[`ASO_STAT_DOWN_BIT] <= (pwr_q != aso_pkg::PWR_ON);
                    PRDATA[`ASO_STAT_SLOW_BIT] <= slow;
                    PRDATA[`ASO_STAT_CRST_BIT] <= (pwr_q == aso_pkg::PWR_RESET);
                    PRDATA[`ASO_STAT_SWPD_BIT] <= (pwr_q == aso_pkg::PWR_DOWN_SW);
                    PRDATA[`ASO_STAT_OE_BIT]   <= oe_s;
                    PRDATA[`ASO_STAT_FMT_LSB +: 2] <= fmt_s;
                end
            end
        end
    end

    // control register, cleared by a qualified reset pin pulse
    always_ff @(posedge CLK) begin
        if (!RST_B || cfg_rst) begin
            pd_q      <= `ASO_PD_RST;
            dll_off_q <= `ASO_DLLOFF_RST;
        end else if (wr_ctrl) begin
            pd_q      <= PWDATA[`ASO_CTRL_PD_BIT];
            dll_off_q <= PWDATA[`ASO_CTRL_DLL_BIT];
        end
    end

    // power state selection
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            aso_pkg::PWR_ON: begin
                if (cfg_rst) pwr_d = aso_pkg::PWR_RESET;
                else if (pd_q) pwr_d = aso_pkg::PWR_DOWN_SW;
                else if (slow) pwr_d = aso_pkg::PWR_DOWN_SLOW;
            end
            aso_pkg::PWR_DOWN_SW: begin
                if (cfg_rst) pwr_d = aso_pkg::PWR_RESET;
                else if (!pd_q) pwr_d = aso_pkg::PWR_ON;
            end
            aso_pkg::PWR_DOWN_SLOW: begin
                if (cfg_rst) pwr_d = aso_pkg::PWR_RESET;
                else if (pd_q) pwr_d = aso_pkg::PWR_DOWN_SW;
                else if (!slow) pwr_d = aso_pkg::PWR_ON;
            end
            aso_pkg::PWR_RESET: begin
                if (!cfg_rst) pwr_d = aso_pkg::PWR_ON;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) pwr_q <= aso_pkg::PWR_ON;
        else pwr_q <= pwr_d;
    end

    // pin-side controls, independent of whether the link clock runs
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            OUT_OE     <= 1'b0;
            DLL_EN     <= 1'b1;
            CORE_PWRDN <= 1'b0;
            run_c_q    <= 1'b0;
            lrst_c_q   <= 1'b1;
        end else begin
            OUT_OE     <= oe_s && (pwr_q == aso_pkg::PWR_ON);
            DLL_EN     <= !dll_off_q;
            CORE_PWRDN <= (pwr_q != aso_pkg::PWR_ON);
            run_c_q    <= (pwr_q == aso_pkg::PWR_ON);
            lrst_c_q   <= cfg_rst;
        end
    end

    // control levels and format pin into the link domain
    aso_sync #(.W(2)) u_ctl_sync (
        .clk (LINK_CLK),
        .d   ({run_c_q, lrst_c_q}),
        .q   ({run_l, lrst_l})
    );

    aso_sync #(.W(2)) u_fmt_sync (
        .clk (LINK_CLK),
        .d   (FMT_SEL),
        .q   (fmt_l)
    );
    assign twos_l = fmt_l[`ASO_FMT_TWOS_BIT];

    // conversion result taken on the falling edge of the input clock
    always_ff @(negedge LINK_CLK) begin
        if (lrst_l) begin
            cap_q <= '0;
        end else begin
            cap_q <= '{code: CORE_CODE, pos: CORE_OVER_POS, neg: CORE_OVER_NEG};
        end
    end

    // heartbeat seen by the slow-clock detector
    always_ff @(posedge LINK_CLK) begin
        if (lrst_l) hb_q <= 1'b0;
        else hb_q <= !hb_q;
    end

    // latency line: half cycle to the first rising edge plus the memory depth
    always_ff @(posedge LINK_CLK) begin
        if (lrst_l) begin
            wr_ptr_q <= '0;
            fill_q   <= '0;
        end else begin
            wr_ptr_q <= next_ptr(wr_ptr_q);
            if (fill_q != FULL) fill_q <= fill_q + PW'(1);
        end
    end

    aso_delay_mem #(
        .W     ($bits(aso_pkg::aso_raw_t)),
        .DEPTH (DEPTH),
        .AW    (PW)
    ) u_line (
        .clk   (LINK_CLK),
        .we    (1'b1),
        .waddr (wr_ptr_q),
        .wdata (cap_q),
        .raddr (next_ptr(wr_ptr_q)),
        .rdata (rd_q)
    );

    // output stage: coding, overdrive clamp, flag and data-ready clock
    always_ff @(posedge LINK_CLK) begin
        if (lrst_l) begin
            SAMPLE_OUT     <= '0;
            OVER_RANGE     <= 1'b0;
            phase_q        <= 1'b0;
            DATA_READY_CLK <= 1'b0;
        end else if (run_l) begin
            if (rd_q.pos) SAMPLE_OUT <= fs_pos(twos_l);
            else if (rd_q.neg) SAMPLE_OUT <= fs_neg(twos_l);
            else if (twos_l) SAMPLE_OUT <= rd_q.code ^ `ASO_TWOS_FLIP;
            else SAMPLE_OUT <= rd_q.code;
            OVER_RANGE     <= rd_q.pos || rd_q.neg || (rd_q.code == `ASO_SOB_POS)
                              || (rd_q.code == `ASO_SOB_NEG);
            phase_q        <= !phase_q;
            DATA_READY_CLK <= !phase_q ^ fmt_l[`ASO_FMT_FALL_BIT];
        end
    end

    // ---- checks in the system clock domain ----
    sequence s_link_idle;
        (idle_q == IDLEC) && !cfg_rst && !pd_q && (pwr_q != aso_pkg::PWR_RESET);
    endsequence

    sequence s_dll_on_write;
        wr_ctrl && !PWDATA[`ASO_CTRL_DLL_BIT] && !cfg_rst;
    endsequence

    a_oe_pin_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        !oe_s |=> !OUT_OE)
        else $error("outputs enabled while the enable pin is low");

    a_pd_tristate: assert property (@(posedge CLK) disable iff (!RST_B)
        (pd_q && !cfg_rst && (pwr_q != aso_pkg::PWR_RESET)) |=> ##1 (!OUT_OE && CORE_PWRDN))
        else $error("power-down bit did not float the outputs");

    a_slow_powerdown: assert property (@(posedge CLK) disable iff (!RST_B)
        s_link_idle |=> (pwr_q == aso_pkg::PWR_DOWN_SLOW) ##1 !OUT_OE)
        else $error("lost link clock did not power the port down");

    a_dll_enable: assert property (@(posedge CLK) disable iff (!RST_B)
        s_dll_on_write |=> ##1 DLL_EN)
        else $error("delay-lock loop not enabled after on mode write");

    a_cfg_reset_held: assert property (@(posedge CLK) disable iff (!RST_B)
        (rstcnt_q == RSTC) |=> ((pwr_q == aso_pkg::PWR_RESET) && !pd_q && !dll_off_q))
        else $error("held reset pin did not reset the configuration");

    // ---- checks in the link clock domain ----
    a_pos_fullscale: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        (run_l && rd_q.pos) |=> (SAMPLE_OUT == fs_pos($past(twos_l))) && OVER_RANGE)
        else $error("positive overdrive code wrong");

    a_neg_fullscale: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        (run_l && rd_q.neg && !rd_q.pos) |=> (SAMPLE_OUT == fs_neg($past(twos_l)))
        && OVER_RANGE)
        else $error("negative overdrive code wrong");

    // the line holds unwritten words until it has filled once after a reset
    a_ovr_aligned: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        (run_l && (fill_q == FULL)) |=> (OVER_RANGE == ((SAMPLE_OUT == fs_pos($past(twos_l)))
        || (SAMPLE_OUT == fs_neg($past(twos_l))))))
        else $error("over-range flag not aligned with its word");

    a_coding_select: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        (run_l && !rd_q.pos && !rd_q.neg) |=> (SAMPLE_OUT == ($past(twos_l)
        ? ($past(rd_q.code) ^ `ASO_TWOS_FLIP) : $past(rd_q.code))))
        else $error("output coding does not follow the format select");

    a_latency_fixed: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        (fill_q == FULL) |-> (rd_q == $past(cap_q, DEPTH)))
        else $error("sample latency differs from 17.5 cycles");

    a_drclk_toggles: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        run_l |=> (phase_q != $past(phase_q)))
        else $error("data-ready clock missed a toggle");

    a_drclk_stops: assert property (@(posedge LINK_CLK) disable iff (lrst_l)
        !run_l |=> ($stable(DATA_READY_CLK) && $stable(SAMPLE_OUT)))
        else $error("outputs moved while powered down");

    a_reset_zero: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
        lrst_l |=> ((SAMPLE_OUT == '0) && !OVER_RANGE))
        else $error("data outputs not low under reset");
endmodule

// >>> tb/aso_capture.sv
// capture model: latches the sample word and flag on each data-ready clock toggle while oe is high
module aso_capture (
    input  wire logic        drc,  // data-ready clock from the port
    input  wire logic        oe,   // port drives its outputs
    input  wire logic [10:0] word, // parallel sample word
    input  wire logic        over_range_flag,  // over-range flag
    output logic      [11:0] cap,  // last captured flag and word
    output int               n_cap // number of data-ready toggles seen
);
    timeunit 1ns;
    timeprecision 100ps;
    // latch a short fixed delay after each toggle so the word has settled
    initial begin
        cap = 12'h000;
        n_cap = 0;
        forever begin
            @(drc);
            #1;
            n_cap++;
            if (oe) begin
                cap = {over_range_flag, word};
            end
        end
    end
endmodule

// >>> tb/test_adc_sample_output_port.sv
// self-checking bench of the sample output port with a capture model
`include "aso_map.svh"
module test_adc_sample_output_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, LINK_CLK;
    logic        CORE_OVER_POS, CORE_OVER_NEG, OE_PIN, CFG_RESET, OVER_RANGE;
    logic        DATA_READY_CLK, OUT_OE, DLL_EN, CORE_PWRDN, lk_run, chk_on;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [10:0] SAMPLE_OUT, CORE_CODE;
    logic [1:0]  FMT_SEL;
    logic [11:0] cap;
    logic [11:0] expq[$];
    int          n_cap, error_cnt, n_checks, cyc, pat;

    aso_top dut_u (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .LINK_CLK, .CORE_CODE, .CORE_OVER_POS, .CORE_OVER_NEG, .FMT_SEL, .OE_PIN,
        .CFG_RESET, .SAMPLE_OUT, .OVER_RANGE, .DATA_READY_CLK, .OUT_OE, .DLL_EN, .CORE_PWRDN);
    aso_capture cap_u (.drc(DATA_READY_CLK), .oe(OUT_OE), .word(SAMPLE_OUT),
        .over_range_flag(OVER_RANGE), .cap(cap), .n_cap(n_cap));

    // system clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // link clock, even duty, parked low while stopped
    initial begin
        LINK_CLK = 1'b0;
        #3;
        forever #32 if (lk_run || LINK_CLK) LINK_CLK = ~LINK_CLK;
    end
    // core results: plain codes, overdrive both ways, raw full-scale codes
    always @(posedge LINK_CLK) begin
        pat <= pat + 1;
        CORE_OVER_POS <= (pat % 8 == 3);
        CORE_OVER_NEG <= (pat % 8 == 5);
        CORE_CODE <= (pat % 8 == 6) ? 11'h7ff : (pat % 8 == 7) ? 11'h000 : 11'(pat * 37);
    end
    // reference of each sample taken, in the coding selected now
    always @(negedge LINK_CLK) begin
        expq.push_back(exp_word(CORE_CODE, CORE_OVER_POS, CORE_OVER_NEG, FMT_SEL));
        if (expq.size() > 40) expq.pop_front();
    end
    // compare each capture with the sample taken 17.5 link cycles before
    always @(posedge LINK_CLK) begin
        #2;
        if (chk_on && expq.size() >= 18) chk(32'(cap), 32'(expq[expq.size()-18]));
    end
    // hang guard
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            results();
        end
    end

    function automatic logic [11:0] exp_word(logic [10:0] c, logic p, logic n, logic [1:0] f);
        logic t;
        t = f[`ASO_FMT_TWOS_BIT];
        if (p) return {1'b1, t ? `ASO_TWO_POS : `ASO_SOB_POS};
        if (n) return {1'b1, t ? `ASO_TWO_NEG : `ASO_SOB_NEG};
        return {(c == 11'h7ff || c == 11'h000), t ? c ^ `ASO_TWOS_FLIP : c};
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(int n);
        repeat (n) @(posedge CLK);
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, logic [31:0] exp, logic err);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        if (!wr) chk(PRDATA, exp);
        chk(32'(PSLVERR), 32'(err));
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic t_regs();
        chk(32'(DLL_EN), 32'h1);
        chk(32'(CORE_PWRDN), 32'h0);
        apb(1'b0, `ASO_CTRL_OFS, 32'h0, 32'h0, 1'b0);
        apb(1'b1, `ASO_STAT_OFS, 32'hffff_ffff, 32'h0, 1'b0);
        apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `ASO_CTRL_OFS, 32'h2, 32'h0, 1'b0);
        wt(3);
        chk(32'(DLL_EN), 32'h0);
        apb(1'b0, `ASO_STAT_OFS, 32'h0, 32'h70, 1'b0);
    endtask

    task automatic t_stream();
        for (int f = 0; f < 4; f++) begin
            FMT_SEL <= 2'(f);
            chk_on <= 1'b0;
            repeat (4) @(posedge LINK_CLK);
            expq.delete();
            chk_on <= 1'b1;
            repeat (30) @(posedge LINK_CLK);
        end
        chk_on <= 1'b0;
    endtask

    task automatic t_oe();
        OE_PIN <= 1'b0;
        wt(5);
        chk(32'(OUT_OE), 32'h0);
        apb(1'b0, `ASO_STAT_OFS, 32'h0, 32'h60, 1'b0);
        OE_PIN <= 1'b1;
        wt(5);
        chk(32'(OUT_OE), 32'h1);
    endtask

    task automatic t_pdn();
        int n;
        apb(1'b1, `ASO_CTRL_OFS, 32'h3, 32'h0, 1'b0);
        wt(5);
        chk(32'(OUT_OE), 32'h0);
        chk(32'(CORE_PWRDN), 32'h1);
        // the stop needs two link edges to cross before the toggles cease
        wt(20);
        n = n_cap;
        wt(50);
        chk(32'(n_cap), 32'(n));
        apb(1'b0, `ASO_STAT_OFS, 32'h0, 32'h79, 1'b0);
        apb(1'b1, `ASO_CTRL_OFS, 32'h2, 32'h0, 1'b0);
        wt(50);
        chk(32'(n_cap > n + 3), 32'h1);
        chk(32'(OUT_OE), 32'h1);
    endtask

    task automatic t_slow();
        lk_run <= 1'b0;
        wt(120);
        chk(32'(CORE_PWRDN), 32'h1);
        apb(1'b0, `ASO_STAT_OFS, 32'h0, 32'h73, 1'b0);
        // loop switched on and off again while the link clock is stopped
        apb(1'b1, `ASO_CTRL_OFS, 32'h0, 32'h0, 1'b0);
        wt(3);
        chk(32'(DLL_EN), 32'h1);
        apb(1'b1, `ASO_CTRL_OFS, 32'h2, 32'h0, 1'b0);
        wt(3);
        chk(32'(DLL_EN), 32'h0);
        lk_run <= 1'b1;
        wt(100);
        chk(32'(CORE_PWRDN), 32'h0);
    endtask

    task automatic t_pinrst();
        CFG_RESET <= 1'b1;
        wt(`ASO_RST_CYC + 40);
        chk(32'(OUT_OE), 32'h0);
        chk(32'(SAMPLE_OUT), 32'h0);
        apb(1'b0, `ASO_CTRL_OFS, 32'h0, 32'h0, 1'b0);
        CFG_RESET <= 1'b0;
        wt(5);
        chk(32'(DLL_EN), 32'h1);
        apb(1'b1, `ASO_CTRL_OFS, 32'h2, 32'h0, 1'b0);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        RST_B = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        CORE_CODE = 11'h000;
        CORE_OVER_POS = 1'b0;
        CORE_OVER_NEG = 1'b0;
        FMT_SEL = 2'h3;
        OE_PIN = 1'b1;
        CFG_RESET = 1'b0;
        lk_run = 1'b1;
        chk_on = 1'b0;
        repeat (16) @(posedge CLK);
        repeat (3) @(posedge LINK_CLK);
        @(posedge CLK);
        RST_B <= 1'b1;
        t_regs();
        t_stream();
        t_oe();
        t_pdn();
        t_slow();
        t_pinrst();
        results();
    end
endmodule
